// ==== hdl/apparent_energy_pkg.sv ====
// Operation
// (RL1) per phase, apparent power is rms voltage times rms current, harmonics included
// (RL2) each phase power sample lands in a 24-bit waveform register
// (RL3) per-phase 24-bit gain scales that phase's apparent power
// (RL4) no offset correction inside the apparent power path
// (RL5) nominal select bit picks nominal voltage times rms current instead
// (RL6) software loads nominal voltage as scaled ratio of nominal to full scale
// (RL7) nominal voltage reads and writes as 32 bits, top byte zero
// (RL8) first stage adds power at 1.024 MHz, pulses and subtracts on threshold
// (RL9) threshold is the 8-bit register shifted left by 27, shared by phases
// (RL10) 32-bit pulse counters per phase, copied to energy register on access
// (RL11) threshold resets to 3; software must never write zero
// (RL12) energy counts up and wraps from max positive to most negative
// (RL13) bit 30 change of any energy counter sets half-full status bit 4
// (RL14) with mask bit 4 set, half-full status drives interrupt pin low
// (RL15) writing status with bit 4 set clears it and releases the pin; the code keeps it set if a half-full event lands in that cycle
// (RL16) clear-on-read bit 6 zeroes an energy register after it is read
// (RL17) connection select bits 5:4 choose phase B voltage source
// (RL18) in three-wire mode software removes phase B from frequency outputs
// (RL19) line-cycle mode transfers counters after programmed half-cycle count
// (RL20) line-cycle apparent accumulation enabled by mode bit 2
// (RL21) software keeps clear-on-read off while line-cycle mode is used
// (RL22) mode bits 5:3 select which phases' zero crossings are counted
// (RL23) in line-cycle mode energy registers hold between transfers
package apparent_energy_pkg;
  localparam logic [7:0] ADDR_GAIN_A = 8'h00;
  localparam logic [7:0] ADDR_GAIN_B = 8'h01;
  localparam logic [7:0] ADDR_GAIN_C = 8'h02;
  localparam logic [7:0] ADDR_NOMINAL = 8'h03;
  localparam logic [7:0] ADDR_THRESHOLD = 8'h04;
  localparam logic [7:0] ADDR_ENERGY_A = 8'h05;
  localparam logic [7:0] ADDR_ENERGY_B = 8'h06;
  localparam logic [7:0] ADDR_ENERGY_C = 8'h07;
  localparam logic [7:0] ADDR_SAMPLE_A = 8'h08;
  localparam logic [7:0] ADDR_SAMPLE_B = 8'h09;
  localparam logic [7:0] ADDR_SAMPLE_C = 8'h0A;
  localparam logic [7:0] ADDR_STATUS = 8'h0B;
  localparam logic [7:0] ADDR_MASK = 8'h0C;
  localparam logic [7:0] ADDR_COMP_MODE = 8'h0D;
  localparam logic [7:0] ADDR_ACC_MODE = 8'h0E;
  localparam logic [7:0] ADDR_LCYC_MODE = 8'h0F;
  localparam logic [7:0] ADDR_HALF_CYCLES = 8'h10;

  localparam int HALF_FULL_POS = 4;
  localparam int ENERGY_HALF_BIT = 30;
  localparam int NOMINAL_SEL_LSB = 11;
  localparam int CONNECTION_SELECT_LSB = 4;
  localparam int LVA_POS = 2;
  localparam int ZERO_CROSS_PHASE_SELECT_LSB = 3;
  localparam int CLEAR_READ_POS = 6;
  localparam int THR_SHIFT = 27;

  localparam logic [7:0] THRESHOLD_RST = 8'h03;
  localparam logic [15:0] HALF_CYCLES_RST = 16'hFFFF;
  localparam logic [1:0] CONNECTION_SELECT_NEG_A = 2'h3;

  localparam int CORE_CLK_KHZ = 20000;
  localparam int ACC_RATE_KHZ = 1024;
  localparam logic [14:0] TICK_STEP = 15'(ACC_RATE_KHZ);
  localparam logic [14:0] TICK_MOD = 15'(CORE_CLK_KHZ);

  typedef enum logic [1:0] {
    LC_OFF = 2'b00,
    LC_SYNC = 2'b01,
    LC_RUN = 2'b11
  } lc_state_t;

  // nominal voltage overrides the measured rms where selected
  function automatic logic [23:0] pick_voltage(input logic nom_sel, input logic [23:0] nom,
                                               input logic [23:0] rms);
    pick_voltage = nom_sel ? nom : rms;
  endfunction
endpackage

// ==== hdl/phase_apparent_power.sv ====
`timescale 1ns/1ns
module phase_apparent_power #(
  parameter int PROD_SHIFT = 23
) (
  input wire logic clk_i,
  input wire logic srst_i,
  input wire logic sample_stb_i,
  input wire logic acc_tick_i,
  input wire logic [23:0] v_rms_i,
  input wire logic [23:0] i_rms_i,
  input wire logic [23:0] gain_i,
  input wire logic [7:0] thr_i,
  output logic [23:0] power_o,
  output logic pulse_o
);
  import apparent_energy_pkg::*;

  typedef struct packed {
    logic [23:0] power;
    logic [35:0] acc;
    logic pulse;
  } phase_state_t;

  phase_state_t r, n;
  logic signed [48:0] prod;
  logic signed [48:0] base;
  logic signed [74:0] gained;
  logic signed [49:0] total;
  logic [35:0] thr_full;
  logic [35:0] sum;

  always_comb begin
    n = r;
    // plain product, no offset term: rms offsets are trimmed upstream [RL1] [RL4]
    // rms inputs are unsigned; zero-extend so full-scale values stay positive
    prod = 49'($signed({1'b0, v_rms_i}) * $signed({1'b0, i_rms_i}));
    base = prod >>> PROD_SHIFT;
    gained = base * $signed(gain_i);
    // gain is signed, full scale of 2^23 gives +/-100 % [RL3]
    total = 50'(base) + 50'(gained >>> 23);
    if (sample_stb_i) begin
      if (total < 0) begin
        n.power = 24'h000000;
      end else if (total > 50'sh7FFFFF) begin
        n.power = 24'h7FFFFF;
      end else begin
        n.power = total[23:0]; // [RL2]
      end
    end
    thr_full = {1'b0, thr_i, 27'h0000000}; // [RL9]
    sum = r.acc + {12'h000, r.power};
    n.pulse = 1'b0;
    if (acc_tick_i) begin
      // power is bounded far below the threshold, so one pulse per tick suffices
      if (sum >= thr_full && thr_i != 8'h00) begin
        n.acc = sum - thr_full; // [RL8]
        n.pulse = 1'b1;
      end else begin
        n.acc = sum;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end

  assign power_o = r.power;
  assign pulse_o = r.pulse;
endmodule // phase_apparent_power

// ==== hdl/apparent_energy_accumulator.sv ====
`timescale 1ns/1ns
module apparent_energy_accumulator #(
  parameter int PROD_SHIFT = 23
) (
  input wire logic CORE_CLK_I,
  input wire logic SRST_I,
  input wire logic SAMPLE_STB_I,
  input wire logic [23:0] VRMS_A_I,
  input wire logic [23:0] VRMS_B_I,
  input wire logic [23:0] VRMS_C_I,
  input wire logic [23:0] IRMS_A_I,
  input wire logic [23:0] IRMS_B_I,
  input wire logic [23:0] IRMS_C_I,
  input wire logic [2:0] ZERO_CROSS_I,
  input wire logic [7:0] REG_ADDR_I,
  input wire logic REG_WR_I,
  input wire logic REG_RD_I,
  input wire logic [31:0] REG_WDATA_I,
  output logic [31:0] REG_RDATA_O,
  output logic FIRST_INTERRUPT_PIN_N_O
);
  import apparent_energy_pkg::*;

  typedef struct packed {
    logic [14:0] frac;
    logic tick;
    logic [2:0][23:0] gain;
    logic [23:0] nominal;
    logic [7:0] threshold;
    logic [2:0] nominal_sel;
    logic [1:0] connection_select;
    logic line_cycle_apparent_enable;
    logic [2:0] zero_cross_phase_select;
    logic clear_rd;
    logic [15:0] half_cycles;
    logic [2:0][31:0] acc;
    logic [2:0][31:0] energy;
    logic half_full;
    logic half_full_mask;
    lc_state_t lc_state;
    logic [15:0] zx_cnt;
    logic [31:0] rdata;
  } top_state_t;

  top_state_t r, n;
  logic [2:0][23:0] volt;
  logic [2:0][23:0] curr;
  logic [2:0][23:0] power;
  logic [2:0] pulse;
  logic [15:0] frac_sum;
  logic zx_hit;
  logic period_end;
  logic [15:0] zx_next;
  logic [31:0] inc;
  logic hf_event;
  int ph;

  // phase B voltage follows connection select; code 10 is reserved and acts as 00
  always_comb begin
    volt[0] = pick_voltage(r.nominal_sel[0], r.nominal, VRMS_A_I); // [RL5]
    volt[1] = pick_voltage(r.nominal_sel[1], r.nominal,
                           (r.connection_select == CONNECTION_SELECT_NEG_A) ? VRMS_A_I : VRMS_B_I); // [RL5] [RL17]
    volt[2] = pick_voltage(r.nominal_sel[2], r.nominal, VRMS_C_I); // [RL5]
    curr[0] = IRMS_A_I;
    curr[1] = IRMS_B_I;
    curr[2] = IRMS_C_I;
  end

  for (genvar g = 0; g < 3; g++) begin : g_phase
    phase_apparent_power #(
      .PROD_SHIFT(PROD_SHIFT)
    ) u_phase (
      .clk_i(CORE_CLK_I),
      .srst_i(SRST_I),
      .sample_stb_i(SAMPLE_STB_I),
      .acc_tick_i(r.tick),
      .v_rms_i(volt[g]),
      .i_rms_i(curr[g]),
      .gain_i(r.gain[g]),
      .thr_i(r.threshold),
      .power_o(power[g]),
      .pulse_o(pulse[g])
    );
  end

  always_comb begin
    n = r;
    inc = 32'h00000000;
    hf_event = 1'b0;
    zx_next = 16'h0000;
    // fractional divider: 1024 ticks per 20000 core cycles, exact on average [RL8]
    frac_sum = {1'b0, r.frac} + {1'b0, TICK_STEP};
    if (frac_sum >= {1'b0, TICK_MOD}) begin
      n.frac = 15'(frac_sum - {1'b0, TICK_MOD});
      n.tick = 1'b1;
    end else begin
      n.frac = frac_sum[14:0];
      n.tick = 1'b0;
    end

    // second stage: plain unsigned add wraps 7FFFFFFF to 80000000 [RL10] [RL12]
    for (ph = 0; ph < 3; ph++) begin
      inc = {31'h00000000, pulse[ph]};
      n.acc[ph] = r.acc[ph] + inc;
      if (n.acc[ph][ENERGY_HALF_BIT] != r.acc[ph][ENERGY_HALF_BIT]) begin
        n.half_full = 1'b1; // [RL13]
        hf_event = 1'b1;
      end
    end

    // line-cycle sequencing; the first crossing only aligns the start [RL19] [RL20]
    zx_hit = |(ZERO_CROSS_I & r.zero_cross_phase_select); // [RL22]
    period_end = 1'b0;
    case (r.lc_state)
      LC_OFF: begin
        if (r.line_cycle_apparent_enable) begin
          n.lc_state = LC_SYNC;
        end
      end
      LC_SYNC: begin
        if (!r.line_cycle_apparent_enable) begin
          n.lc_state = LC_OFF;
        end else if (zx_hit) begin
          n.lc_state = LC_RUN;
          n.zx_cnt = 16'h0000;
          for (ph = 0; ph < 3; ph++) begin
            n.acc[ph] = {31'h00000000, pulse[ph]};
          end
        end
      end
      LC_RUN: begin
        if (!r.line_cycle_apparent_enable) begin
          n.lc_state = LC_OFF;
        end else if (zx_hit) begin
          zx_next = r.zx_cnt + 16'h0001;
          if (zx_next >= r.half_cycles) begin
            period_end = 1'b1;
            n.zx_cnt = 16'h0000;
          end else begin
            n.zx_cnt = zx_next;
          end
        end
      end
      default: begin
        n.lc_state = LC_OFF;
      end
    endcase
    if (period_end) begin
      // transfer then restart; pulse of this cycle counts in the transfer and also opens the next period [RL19] [RL23]
      for (ph = 0; ph < 3; ph++) begin
        n.energy[ph] = r.acc[ph] + {31'h00000000, pulse[ph]};
        n.acc[ph] = {31'h00000000, pulse[ph]};
      end
    end

    // register reads: data appears one cycle after the strobe
    if (REG_RD_I) begin
      case (REG_ADDR_I)
        ADDR_GAIN_A: n.rdata = {8'h00, r.gain[0]};
        ADDR_GAIN_B: n.rdata = {8'h00, r.gain[1]};
        ADDR_GAIN_C: n.rdata = {8'h00, r.gain[2]};
        ADDR_NOMINAL: n.rdata = {8'h00, r.nominal}; // [RL7]
        ADDR_THRESHOLD: n.rdata = {24'h000000, r.threshold};
        ADDR_ENERGY_A, ADDR_ENERGY_B, ADDR_ENERGY_C: begin
          ph = int'(REG_ADDR_I - ADDR_ENERGY_A);
          if (r.lc_state == LC_OFF) begin
            // free-running: the read itself snapshots the counter [RL10]
            n.rdata = r.acc[ph];
            n.energy[ph] = r.acc[ph];
            if (r.clear_rd) begin
              // a pulse landing in the read cycle is kept [RL16]
              n.acc[ph] = {31'h00000000, pulse[ph]};
              n.energy[ph] = 32'h00000000;
            end
          end else begin
            n.rdata = r.energy[ph]; // [RL23]
            if (r.clear_rd) begin
              // clearing mid-period restarts accumulation too [RL16] [RL21]
              n.energy[ph] = 32'h00000000;
              n.acc[ph] = {31'h00000000, pulse[ph]};
            end
          end
        end
        ADDR_SAMPLE_A: n.rdata = {8'h00, power[0]}; // [RL2]
        ADDR_SAMPLE_B: n.rdata = {8'h00, power[1]}; // [RL2]
        ADDR_SAMPLE_C: n.rdata = {8'h00, power[2]}; // [RL2]
        ADDR_STATUS: n.rdata = 32'(r.half_full) << HALF_FULL_POS;
        ADDR_MASK: n.rdata = 32'(r.half_full_mask) << HALF_FULL_POS;
        ADDR_COMP_MODE: n.rdata = 32'(r.nominal_sel) << NOMINAL_SEL_LSB;
        ADDR_ACC_MODE: n.rdata = 32'(r.connection_select) << CONNECTION_SELECT_LSB;
        ADDR_LCYC_MODE: begin
          n.rdata = (32'(r.line_cycle_apparent_enable) << LVA_POS) | (32'(r.zero_cross_phase_select) << ZERO_CROSS_PHASE_SELECT_LSB)
                    | (32'(r.clear_rd) << CLEAR_READ_POS);
        end
        ADDR_HALF_CYCLES: n.rdata = {16'h0000, r.half_cycles};
        default: n.rdata = 32'h00000000;
      endcase
    end

    // register writes; read-only and unmapped addresses ignore writes
    if (REG_WR_I) begin
      case (REG_ADDR_I)
        ADDR_GAIN_A: n.gain[0] = REG_WDATA_I[23:0]; // [RL3]
        ADDR_GAIN_B: n.gain[1] = REG_WDATA_I[23:0]; // [RL3]
        ADDR_GAIN_C: n.gain[2] = REG_WDATA_I[23:0]; // [RL3]
        ADDR_NOMINAL: n.nominal = REG_WDATA_I[23:0]; // [RL7]
        ADDR_THRESHOLD: n.threshold = REG_WDATA_I[7:0]; // [RL11]
        ADDR_STATUS: begin
          // write-one clears, but a same-cycle event keeps the flag [RL15]
          if (REG_WDATA_I[HALF_FULL_POS] && !hf_event) begin
            n.half_full = 1'b0;
          end
        end
        ADDR_MASK: n.half_full_mask = REG_WDATA_I[HALF_FULL_POS];
        ADDR_COMP_MODE: n.nominal_sel = REG_WDATA_I[NOMINAL_SEL_LSB +: 3]; // [RL5]
        ADDR_ACC_MODE: n.connection_select = REG_WDATA_I[CONNECTION_SELECT_LSB +: 2]; // [RL17]
        ADDR_LCYC_MODE: begin
          n.line_cycle_apparent_enable = REG_WDATA_I[LVA_POS]; // [RL20]
          n.zero_cross_phase_select = REG_WDATA_I[ZERO_CROSS_PHASE_SELECT_LSB +: 3]; // [RL22]
          n.clear_rd = REG_WDATA_I[CLEAR_READ_POS]; // [RL16]
        end
        ADDR_HALF_CYCLES: n.half_cycles = REG_WDATA_I[15:0];
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge CORE_CLK_I) begin
    if (SRST_I) begin
      r <= '0;
      r.threshold <= THRESHOLD_RST; // [RL11]
      r.half_cycles <= HALF_CYCLES_RST;
      r.lc_state <= LC_OFF;
    end else begin
      r <= n;
    end
  end

  assign REG_RDATA_O = r.rdata;
  // pin follows the sticky flag gated by the mask, so it releases when either the flag or the mask clears [RL14] [RL15]
  assign FIRST_INTERRUPT_PIN_N_O = ~(r.half_full & r.half_full_mask);
endmodule // apparent_energy_accumulator

// ==== bench/apparent_energy_props.sv ====
`timescale 1ns/1ns
module apparent_energy_props (
  input wire logic CORE_CLK_I,
  input wire logic SRST_I,
  input wire logic [7:0] REG_ADDR_I,
  input wire logic REG_WR_I,
  input wire logic REG_RD_I,
  input wire logic [31:0] REG_WDATA_I,
  input wire logic [31:0] REG_RDATA_O,
  input wire logic FIRST_INTERRUPT_PIN_N_O
);
  import apparent_energy_pkg::*;
  default clocking cb @(posedge CORE_CLK_I);
  endclocking
  default disable iff (SRST_I);
  a_rdata_hold: assert property (!REG_RD_I |=> $stable(REG_RDATA_O))
    else $error("read data moved without a read");
  a_gain_width: assert property (REG_RD_I && REG_ADDR_I < ADDR_NOMINAL
    |=> REG_RDATA_O[31:24] == 8'h00) else $error("gain top byte not zero");
  a_nom_width: assert property (REG_RD_I && REG_ADDR_I == ADDR_NOMINAL
    |=> REG_RDATA_O[31:24] == 8'h00) else $error("nominal top byte not zero");
  a_sample_width: assert property (REG_RD_I && REG_ADDR_I inside {[8'h08:8'h0A]}
    |=> REG_RDATA_O[31:24] == 8'h00) else $error("sample top byte not zero");
  a_thr_back: assert property (REG_WR_I && REG_ADDR_I == ADDR_THRESHOLD ##1 !REG_WR_I ##1
    REG_RD_I && !REG_WR_I && REG_ADDR_I == ADDR_THRESHOLD
    |=> REG_RDATA_O == ($past(REG_WDATA_I, 3) & 32'h000000FF)) else $error("threshold lost");
  a_irq_ack: assert property (REG_WR_I && REG_ADDR_I == ADDR_STATUS &&
    REG_WDATA_I[HALF_FULL_POS] |=> FIRST_INTERRUPT_PIN_N_O) else $error("pin low after ack");
  a_irq_unmask: assert property (REG_WR_I && REG_ADDR_I == ADDR_MASK &&
    !REG_WDATA_I[HALF_FULL_POS] |=> FIRST_INTERRUPT_PIN_N_O) else $error("masked pin low");
  // low pin must wait for software; it never lets go by itself
  a_irq_hold: assert property (!FIRST_INTERRUPT_PIN_N_O && !(REG_WR_I &&
    (REG_ADDR_I == ADDR_STATUS || REG_ADDR_I == ADDR_MASK)) |=> !FIRST_INTERRUPT_PIN_N_O)
    else $error("pin released without ack");
  c_thr_write: cover property (REG_WR_I && REG_ADDR_I == ADDR_THRESHOLD);
  c_energy_read: cover property (REG_RD_I && REG_ADDR_I == ADDR_ENERGY_A);
  c_irq_fall: cover property ($fell(FIRST_INTERRUPT_PIN_N_O));
endmodule // apparent_energy_props

bind apparent_energy_accumulator apparent_energy_props props (.CORE_CLK_I(CORE_CLK_I),
  .SRST_I(SRST_I), .REG_ADDR_I(REG_ADDR_I), .REG_WR_I(REG_WR_I), .REG_RD_I(REG_RD_I),
  .REG_WDATA_I(REG_WDATA_I), .REG_RDATA_O(REG_RDATA_O),
  .FIRST_INTERRUPT_PIN_N_O(FIRST_INTERRUPT_PIN_N_O));

// ==== bench/energy_host.sv ====
`timescale 1ns/1ns
module energy_host (
  input wire logic clk_i,
  input wire logic [31:0] rdata_i,
  output logic [7:0] addr_o = 8'h00,
  output logic wr_o = 1'b0,
  output logic rd_o = 1'b0,
  output logic [31:0] wdata_o = 32'h00000000
);
  import apparent_energy_pkg::*;
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    addr_o = a;
    wdata_o = d;
    if (a == ADDR_NOMINAL) wdata_o = {8'h00, d[23:0]};
    if (a == ADDR_THRESHOLD && d[7:0] == 8'h00) wdata_o = 32'h00000003;
    wr_o = 1'b1;
    @(posedge clk_i);
    #1;
    wr_o = 1'b0;
    // idle bus flips so a stale value cannot pass for a live one
    addr_o = ~addr_o;
    wdata_o = ~wdata_o;
    // one idle edge, so the next strobe never rises in this time step
    @(posedge clk_i);
    #1;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    addr_o = a;
    rd_o = 1'b1;
    @(posedge clk_i);
    #1;
    rd_o = 1'b0;
    addr_o = ~addr_o;
    d = rdata_i;
    @(posedge clk_i);
    #1;
  endtask
endmodule // energy_host

// ==== bench/apparent_energy_accumulator_test.sv ====
`timescale 1ns/1ns
module apparent_energy_accumulator_test;
  import apparent_energy_pkg::*;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic stb = 1'b0;
  logic [23:0] va = 24'h400000, vb = 24'h200000, vc = 24'h400000;
  logic [23:0] ia = 24'h400000, ib = 24'h400000, ic = 24'h400000;
  logic [2:0] zx = 3'h0;
  logic [7:0] addr;
  logic wr, rd, irq_n;
  logic [31:0] wdata, rdata, r, q;
  int mismatches = 0;
  int comparisons = 0;
  always #25 clk = ~clk;
  apparent_energy_accumulator #(.PROD_SHIFT(23)) dut (.CORE_CLK_I(clk), .SRST_I(srst),
    .SAMPLE_STB_I(stb), .VRMS_A_I(va), .VRMS_B_I(vb), .VRMS_C_I(vc), .IRMS_A_I(ia),
    .IRMS_B_I(ib), .IRMS_C_I(ic), .ZERO_CROSS_I(zx), .REG_ADDR_I(addr), .REG_WR_I(wr),
    .REG_RD_I(rd), .REG_WDATA_I(wdata), .REG_RDATA_O(rdata), .FIRST_INTERRUPT_PIN_N_O(irq_n));
  energy_host host (.clk_i(clk), .rdata_i(rdata), .addr_o(addr), .wr_o(wr), .rd_o(rd),
    .wdata_o(wdata));
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      mismatches++;
      $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask
  // pulse counts drift by one with tick phase and leftover sum
  task automatic in_range(input logic [31:0] v, input int lo, input int hi);
    check({31'h0, v >= 32'(lo) && v <= 32'(hi)}, 32'h00000001);
  endtask
  function automatic logic [31:0] pw(input logic [23:0] v, input logic [23:0] i,
                                     input logic [23:0] g);
    longint p;
    p = longint'((64'(v) * 64'(i)) >> 23);
    p = p + ((p * longint'($signed(g))) >>> 23);
    if (p < 64'sh0) p = 64'sh0;
    if (p > 64'sh7FFFFF) p = 64'sh7FFFFF;
    return 32'(p);
  endfunction
  task automatic zxp(input logic [2:0] m);
    zx = m;
    tick(1);
    zx = 3'h0;
  endtask
  task automatic samples(input logic [23:0] vae, input logic [23:0] vbe);
    stb = 1'b1;
    tick(1);
    stb = 1'b0;
    tick(2);
    host.rd(ADDR_SAMPLE_A, r);
    check(r, pw(vae, ia, 24'h000000));
    host.rd(ADDR_SAMPLE_B, r);
    check(r, pw(vbe, ib, 24'h400000));
    host.rd(ADDR_SAMPLE_C, r);
    check(r, pw(vc, ic, 24'hC00000));
  endtask
  task automatic t_regs();
    host.rd(ADDR_THRESHOLD, r);
    check(r, 32'h00000003);
    host.rd(ADDR_STATUS, r);
    check(r, 32'h00000000);
    host.wr(ADDR_ENERGY_A, 32'h00001234);
    host.rd(ADDR_ENERGY_A, r);
    check(r, 32'h00000000);
    host.wr(ADDR_GAIN_A, 32'hFF876543);
    host.rd(ADDR_GAIN_A, r);
    check(r, 32'h00876543);
    host.wr(ADDR_GAIN_A, 32'h00000000);
    host.wr(ADDR_MASK, 32'h00000010);
    host.rd(ADDR_MASK, r);
    check(r, 32'h00000010);
    check({31'h0, irq_n}, 32'h00000001);
    host.wr(ADDR_STATUS, 32'h00000010);
    check({31'h0, irq_n}, 32'h00000001);
    host.wr(ADDR_MASK, 32'h00000000);
  endtask
  task automatic t_power();
    host.wr(ADDR_GAIN_B, 32'h00400000);
    host.wr(ADDR_GAIN_C, 32'h00C00000);
    samples(va, vb);
    host.wr(ADDR_ACC_MODE, 32'h00000030);
    samples(va, va);
    host.wr(ADDR_ACC_MODE, 32'h00000000);
    host.wr(ADDR_NOMINAL, 32'hAB300000);
    host.rd(ADDR_NOMINAL, r);
    check(r, 32'h00300000);
    host.wr(ADDR_COMP_MODE, 32'h00000800);
    samples(24'h300000, vb);
    host.wr(ADDR_COMP_MODE, 32'h00001000);
    samples(va, 24'h300000);
    host.wr(ADDR_COMP_MODE, 32'h00000000);
  endtask
  task automatic t_energy();
    {va, vb, vc, ia, ib, ic} = {6{24'hFFFFFF}};
    host.wr(ADDR_THRESHOLD, 32'h00000001);
    stb = 1'b1;
    tick(1);
    stb = 1'b0;
    host.wr(ADDR_LCYC_MODE, 32'h00000040);
    host.rd(ADDR_ENERGY_A, r);
    host.rd(ADDR_ENERGY_A, r);
    in_range(r, 0, 1);
    tick(4000);
    host.rd(ADDR_ENERGY_A, r);
    in_range(r, 11, 14);
    host.wr(ADDR_THRESHOLD, 32'h00000002);
    host.rd(ADDR_THRESHOLD, r);
    check(r, 32'h00000002);
    host.rd(ADDR_ENERGY_C, r);
    tick(4000);
    host.rd(ADDR_ENERGY_C, r);
    in_range(r, 5, 8);
    host.wr(ADDR_LCYC_MODE, 32'h00000000);
    host.rd(ADDR_ENERGY_B, q);
    tick(2000);
    host.rd(ADDR_ENERGY_B, r);
    check({31'h0, r > q}, 32'h00000001);
  endtask
  task automatic t_lcyc();
    host.wr(ADDR_HALF_CYCLES, 32'h00000002);
    host.wr(ADDR_LCYC_MODE, 32'h0000000C);
    zxp(3'b001);
    tick(4000);
    zxp(3'b001);
    zxp(3'b010);
    host.rd(ADDR_ENERGY_A, q);
    tick(1000);
    host.rd(ADDR_ENERGY_A, r);
    check(r, q);
    tick(2990);
    zxp(3'b001);
    tick(2);
    host.rd(ADDR_ENERGY_A, r);
    in_range(r, 11, 14);
  endtask
  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  initial begin
    tick(2);
    srst = 1'b0;
    t_regs();
    t_power();
    t_energy();
    t_lcyc();
    end_of_test();
  end
  // about twice the expected run
  initial begin
    #2000000;
    mismatches++;
    end_of_test();
  end
endmodule // apparent_energy_accumulator_test
